// [include/asrc_pkg.sv]
// constants shared by the static memory host controller
// assumes a 100 MHz system clock driving the controller
package asrc_pkg;
	localparam int ADDR_W = 18;
	localparam int DATA_W = 8;
	localparam int CLK_PERIOD_PS = 10000;
	// slow grade minimum times, in picoseconds
	localparam int WRITE_CYCLE_PS = 10000;
	localparam int SELECT_TO_END_PS = 8000;
	localparam int ADDR_TO_END_PS = 8000;
	localparam int STROBE_WIDTH_OUTPUTS_OFF_PS = 7000;
	localparam int STROBE_WIDTH_OUTPUTS_ON_PS = 8000;
	localparam int DATA_SETUP_PS = 5000;
	localparam int READ_CYCLE_PS = 10000;
	localparam int READ_ACCESS_PS = 10000;
	localparam int STROBE_LOW_TO_FLOAT_PS = 4000;
	// least times round up to whole cycles, at least one
	function automatic int min_cycles(input int ps);
		int c;
		c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
		return (c < 1) ? 1 : c;
	endfunction
	localparam int WRITE_LOW_CYCLES_I = min_cycles(STROBE_WIDTH_OUTPUTS_ON_PS) >
		min_cycles(SELECT_TO_END_PS) ? min_cycles(STROBE_WIDTH_OUTPUTS_ON_PS)
		: min_cycles(SELECT_TO_END_PS);
	localparam logic [3:0] WRITE_LOW_CYCLES = 4'(WRITE_LOW_CYCLES_I + 1);
	localparam logic [3:0] WRITE_GAP_CYCLES = 4'(min_cycles(WRITE_CYCLE_PS));
	localparam logic [3:0] READ_CYCLES = 4'(min_cycles(READ_ACCESS_PS) + 1);
	typedef enum logic [2:0] {
		ASRC_IDLE = 3'b000,
		ASRC_WSETUP = 3'b001,
		ASRC_WLOW = 3'b010,
		ASRC_WEND = 3'b011,
		ASRC_READ = 3'b100,
		ASRC_DONE = 3'b101
	} asrc_state_t;
endpackage

// [rtl/asrc_count.sv]
// down counter for phase durations
// assumes load and enable synchronous to clk_sys
`timescale 1ns/1ps
`default_nettype none
module asrc_count #(
	parameter int W = 4
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic ce,
	input wire logic load,
	input wire logic [W-1:0] load_value,
	output logic zero
);
	logic [W-1:0] count;
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			count <= '0;
		end else if (ce) begin
			if (load) begin
				count <= load_value;
			end else if (count != '0) begin
				count <= count - W'(1);
			end
		end
	end
	assign zero = (count == '0);
endmodule // asrc_count
`default_nettype wire

// [rtl/asrc_host.sv]
// host controller for an asynchronous 256k by 8 static memory
// assumes the memory pins sit on clk_sys flip-flops; data_lines read synchronously
// Operation
// - write only while select and strobe overlap
// - controls valid first; strobe rise ends write
// - data held through the terminating edge
// - successive writes spaced by write cycle
// - select low long enough before end
// - address stable long before write end
// - strobe width covers output-enable case
// - stop driving data when strobe rises
// - strobe held high during every read
// - address-driven read updates memory outputs
// - address valid before select falls (reads launch the address on the same edge that drops select)
`timescale 1ns/1ps
`default_nettype none
module asrc_host
	import asrc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic ce,
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [asrc_pkg::ADDR_W-1:0] req_addr,
	input wire logic [asrc_pkg::DATA_W-1:0] req_wdata,
	output logic req_ready,
	output logic rsp_valid,
	output logic [asrc_pkg::DATA_W-1:0] rsp_rdata,
	output logic [asrc_pkg::ADDR_W-1:0] word_address,
	output logic chip_select_n,
	output logic write_strobe_n,
	output logic output_enable_n,
	input wire logic [asrc_pkg::DATA_W-1:0] data_lines_in,
	output logic [asrc_pkg::DATA_W-1:0] data_lines_out,
	output logic data_lines_oe
);
	asrc_state_t state;
	logic cnt_load;
	logic [3:0] cnt_value;
	logic cnt_zero;
	logic gap_load;
	logic gap_zero;

	asrc_count #(.W(4)) u_phase (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.ce(ce),
		.load(cnt_load),
		.load_value(cnt_value),
		.zero(cnt_zero)
	);

	asrc_count #(.W(4)) u_gap (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.ce(ce),
		.load(gap_load),
		.load_value(WRITE_GAP_CYCLES),
		.zero(gap_zero)
	);

	// accept only when idle and write spacing elapsed
	wire logic take = (state == ASRC_IDLE) && req_valid && gap_zero;
	assign gap_load = ce && (state == ASRC_WSETUP);
	assign cnt_load = take || (state == ASRC_WSETUP);
	assign cnt_value = (state == ASRC_WSETUP) ? WRITE_LOW_CYCLES : READ_CYCLES;

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			state <= ASRC_IDLE;
		end else if (ce) begin
			unique case (state)
				ASRC_IDLE: begin
					if (take) begin
						state <= req_write ? ASRC_WSETUP : ASRC_READ;
					end
				end
				ASRC_WSETUP: begin
					state <= ASRC_WLOW;
				end
				ASRC_WLOW: begin
					if (cnt_zero) begin
						state <= ASRC_WEND;
					end
				end
				ASRC_WEND: begin
					state <= ASRC_DONE;
				end
				ASRC_READ: begin
					if (cnt_zero) begin
						state <= ASRC_DONE;
					end
				end
				ASRC_DONE: begin
					state <= ASRC_IDLE;
				end
				default: begin
					state <= ASRC_IDLE;
				end
			endcase
		end
	end

	// address launched with the request, on the read select edge and one cycle before the write select edge
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			word_address <= '0;
			data_lines_out <= '0;
		end else if (ce && take) begin
			word_address <= req_addr;
			data_lines_out <= req_wdata;
		end
	end

	// pin controls; output enable stays high during writes
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			chip_select_n <= 1'b1;
			write_strobe_n <= 1'b1;
			output_enable_n <= 1'b1;
			data_lines_oe <= 1'b0;
		end else if (ce) begin
			chip_select_n <= 1'b1;
			write_strobe_n <= 1'b1;
			output_enable_n <= 1'b1;
			data_lines_oe <= 1'b0;
			if (take && !req_write) begin
				chip_select_n <= 1'b0;
				output_enable_n <= 1'b0;
			end else if (state == ASRC_READ && !cnt_zero) begin
				chip_select_n <= 1'b0;
				output_enable_n <= 1'b0;
			end else if (state == ASRC_WSETUP) begin
				// select and strobe fall together after address settled
				chip_select_n <= 1'b0;
				write_strobe_n <= 1'b0;
			end else if (state == ASRC_WLOW) begin
				chip_select_n <= 1'b0;
				write_strobe_n <= cnt_zero;
				data_lines_oe <= !cnt_zero;
			end else if (state == ASRC_WEND) begin
				// data released on the strobe rise edge, as AST_DRV forbids driving once the strobe is high; release select
				chip_select_n <= 1'b1;
			end
		end
	end

	// read data sampled at the end of the access time
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rsp_valid <= 1'b0;
			rsp_rdata <= '0;
			req_ready <= 1'b0;
		end else if (ce) begin
			rsp_valid <= (state == ASRC_READ && cnt_zero) || state == ASRC_WEND;
			if (state == ASRC_READ && cnt_zero) begin
				rsp_rdata <= data_lines_in;
			end
			req_ready <= (state == ASRC_IDLE) && gap_zero && !take;
		end
	end
endmodule // asrc_host
`default_nettype wire

// [verif/asrc_host_props.sv]
// pin checker for the static memory host controller
// assumes binding into asrc_host, one clock domain
`timescale 1ns/1ps
`default_nettype none
module asrc_host_props (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic [17:0] word_address,
	input wire logic chip_select_n,
	input wire logic write_strobe_n,
	input wire logic output_enable_n,
	input wire logic data_lines_oe
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	AST_WIN: assert property (!write_strobe_n |-> !chip_select_n) else $error("no select");
	AST_END: assert property ($rose(write_strobe_n) |-> !chip_select_n) else $error("end");
	AST_SEL: assert property ($rose(write_strobe_n) |-> !$past(chip_select_n, 2)) else $error("sel");
	AST_ADR: assert property (!write_strobe_n |=> $stable(word_address)) else $error("addr");
	AST_WID: assert property ($fell(write_strobe_n) |=> !write_strobe_n) else $error("width");
	AST_REL: assert property ($rose(write_strobe_n) |-> !data_lines_oe) else $error("release");
	AST_RDW: assert property (!output_enable_n |-> write_strobe_n) else $error("read strobe");
	AST_DRV: assert property (data_lines_oe |-> !write_strobe_n && output_enable_n) else $error("drv");
endmodule // asrc_host_props
bind asrc_host asrc_host_props i_props (
	.clk_sys(clk_sys),
	.nrst(nrst),
	.word_address(word_address),
	.chip_select_n(chip_select_n),
	.write_strobe_n(write_strobe_n),
	.output_enable_n(output_enable_n),
	.data_lines_oe(data_lines_oe)
);
`default_nettype wire

// [verif/asrc_mem_model.sv]
// behavioural 256k by 8 static memory on the host pins
// assumes the bench resolves the shared data bus
`timescale 1ns/1ps
`default_nettype none
module asrc_mem_model #(
	parameter int DLY = 1
) (
	input wire logic [17:0] word_address,
	input wire logic chip_select_n,
	input wire logic write_strobe_n,
	input wire logic output_enable_n,
	input wire logic host_oe,
	input wire logic [7:0] wdata,
	output logic [7:0] data_lines
);
	logic [7:0] mem [262144];
	logic [7:0] last = 8'h00;
	wire rd = !chip_select_n && write_strobe_n && !output_enable_n;
	always @(chip_select_n, write_strobe_n, host_oe, word_address, wdata) begin
		if (!chip_select_n && !write_strobe_n && host_oe) mem[word_address] = wdata;
	end
	always @(chip_select_n, write_strobe_n, output_enable_n, word_address) begin
		if (rd) last = mem[word_address];
	end
	// released lines show the inverse of the last byte
	assign #(DLY) data_lines = rd ? mem[word_address] : ~last;
endmodule // asrc_mem_model
`default_nettype wire

// [verif/tb_top.sv]
// bench for the static memory host controller
// assumes the memory model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk_sys = 0, nrst = 0, ce = 1, req_valid = 0, req_write = 0, req_ready, rsp_valid;
	logic [17:0] req_addr = 0, word_address;
	logic [7:0] req_wdata = 0, rsp_rdata, dout, mq;
	logic cs_n, we_n, oe_n, doe;
	wire [7:0] bus = doe ? dout : mq;
	int mismatches = 0, comparisons = 0;
	asrc_host i_dut (.clk_sys, .nrst, .ce, .req_valid, .req_write, .req_addr, .req_wdata,
		.req_ready, .rsp_valid, .rsp_rdata, .word_address, .chip_select_n(cs_n),
		.write_strobe_n(we_n), .output_enable_n(oe_n), .data_lines_in(bus),
		.data_lines_out(dout), .data_lines_oe(doe));
	asrc_mem_model i_mem (.word_address, .chip_select_n(cs_n), .write_strobe_n(we_n),
		.output_enable_n(oe_n), .host_oe(doe), .wdata(bus), .data_lines(mq));
	initial forever #5 clk_sys = ~clk_sys;
	task automatic tally_and_finish;
		$display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// ready seen high at an edge with valid low: the next edge takes the request
	task automatic xfer(input logic w, input logic [17:0] a, input logic [7:0] d);
		int n;
		n = 0;
		do @(posedge clk_sys); while (req_ready !== 1'b1 && ++n < 50);
		if (n >= 50) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, req_ready, 1'b1);
		end
		req_valid <= 1;
		req_write <= w;
		req_addr <= a;
		req_wdata <= d;
		@(posedge clk_sys);
		req_valid <= 0;
		n = 0;
		do @(negedge clk_sys); while (rsp_valid !== 1'b1 && ++n < 50);
		if (n >= 50) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, rsp_valid, 1'b1);
		end
		@(posedge clk_sys);
	endtask
	task automatic t_bounds;
		logic [17:0] a[3] = '{18'h0_0000, 18'h3_ffff, 18'h1_2345};
		foreach (a[i]) xfer(1, a[i], 8'ha5 ^ 8'(i));
		foreach (a[i]) begin
			xfer(0, a[i], 8'h00);
			chk(rsp_rdata, 8'ha5 ^ 8'(i));
		end
	endtask
	task automatic t_overwrite;
		xfer(1, 18'h0_0101, 8'h3c);
		xfer(1, 18'h0_0100, 8'h11);
		xfer(1, 18'h0_0100, 8'hee);
		xfer(0, 18'h0_0100, 8'h00);
		chk(rsp_rdata, 8'hee);
		xfer(0, 18'h0_0101, 8'h00);
		chk(rsp_rdata, 8'h3c);
	endtask
	task automatic t_ce_hold;
		ce <= 0;
		req_valid <= 1;
		req_write <= 1;
		req_addr <= 18'h2_0000;
		req_wdata <= 8'h5a;
		repeat (4) begin
			@(negedge clk_sys);
			chk(8'({cs_n, we_n}), 8'h03);
		end
		@(posedge clk_sys);
		// drop the frozen request so it is not taken on the first edge after enable returns
		req_valid <= 0;
		ce <= 1;
		xfer(1, 18'h2_0000, 8'h5a);
		xfer(0, 18'h2_0000, 8'h00);
		chk(rsp_rdata, 8'h5a);
	endtask
	task automatic t_reset;
		req_valid <= 1;
		req_write <= 1;
		req_addr <= 18'h0_0040;
		repeat (3) @(posedge clk_sys);
		req_valid <= 0;
		nrst <= 0;
		@(negedge clk_sys);
		chk(8'({cs_n, we_n, oe_n, doe}), 8'h0e);
		@(posedge clk_sys);
		nrst <= 1;
		xfer(0, 18'h3_ffff, 8'h00);
		chk(rsp_rdata, 8'ha4);
	endtask
	initial begin
		repeat (3) @(posedge clk_sys);
		nrst <= 1;
		@(posedge clk_sys);
		t_bounds();
		t_overwrite();
		t_ce_hold();
		t_reset();
		tally_and_finish();
	end
	initial begin
		#100000;
		mismatches++;
		tally_and_finish();
	end
endmodule // tb_top
`default_nettype wire
